/* File: verilog/drax_data_access.sv */
// top: scratchpad, aux RAM, special registers and multiplexed external bus
`timescale 1ns/1ps
`default_nettype none
module drax_data_access (
  input wire logic core_clk,
  input wire logic rst,
  input wire drax_pkg::drax_req_t coreReq,
  output logic reqReady,
  output drax_pkg::drax_rsp_t coreRsp,
  input wire logic pullupRequest,
  input wire logic external_access_n,
  input wire logic [7:0] lowPortIn,
  output drax_pkg::drax_pins_t pins
);
  import drax_pkg::*;

  typedef enum logic [1:0] {ExIdle, ExWait, ExAddr, ExData} drax_ext_t;
  typedef enum logic [1:0] {SrcNone, SrcScratch, SrcAux, SrcSfr} drax_src_t;

  function automatic logic isExtMove(input drax_op_t op);
    return (op == OP_EXTMOVE_BANKPTR) || (op == OP_EXTMOVE_DATAPTR);
  endfunction

  logic extAccMeta, extAccSync;
  // pin fields are separate flops so that each has a single writer process
  logic [7:0] lowOut_q, upper_q;
  logic lowOe_q, ale_q, storeStrobeN_q, writeN_q, readN_q, pullupEn_q;
  assign pins = '{lowOut: lowOut_q, lowOe: lowOe_q, upper: upper_q, ale: ale_q,
                  storeStrobeN: storeStrobeN_q, writeN: writeN_q, readN: readN_q,
                  pullupEn: pullupEn_q};
  logic [7:0] portMeta, portSync;
  logic [7:0] xramHigh_q, chipCtrl_q;
  logic [1:0] keyStage_q;
  logic [2:0] phase_q;
  drax_ext_t ext_q;
  drax_src_t src_q;
  logic pend_q, curWrite_q, curFetch_q;
  logic [15:0] curAddr_q;
  logic [7:0] curData_q, sfrData_q;
  logic [7:0] spRdata, auxRdata;

  // both pin inputs cross two flops before any logic sees them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      extAccMeta <= 1'b1;
      extAccSync <= 1'b1;
      portMeta <= 8'hFF;
      portSync <= 8'hFF;
    end else begin
      extAccMeta <= external_access_n;
      extAccSync <= extAccMeta;
      portMeta <= lowPortIn;
      portSync <= portMeta;
    end
  end

  logic accept, isDirectSfr, spWe, spHit, auxHit, extGo, sfrWe;
  logic [15:0] extMoveAddr;
  assign accept = coreReq.valid && reqReady;
  // bank-pointer moves take the upper byte from the aux high address register
  assign extMoveAddr = (coreReq.op == OP_EXTMOVE_BANKPTR) ?
                       {xramHigh_q, coreReq.addr[7:0]} : coreReq.addr;
  assign isDirectSfr = (coreReq.op == OP_DIRECT) && (coreReq.addr[7:0] > DIRECT_LIMIT);
  assign spHit = accept && ((coreReq.op == OP_INDIRECT) ||
                 ((coreReq.op == OP_DIRECT) && !isDirectSfr));
  assign spWe = spHit && coreReq.write;
  assign auxHit = accept && isExtMove(coreReq.op) && chipCtrl_q[CHIP_CTRL_AUX_BIT] &&
                  (extMoveAddr <= AUX_LIMIT);
  assign extGo = accept && ((isExtMove(coreReq.op) && !auxHit) ||
                 ((coreReq.op == OP_FETCH) && !extAccSync));
  assign sfrWe = accept && isDirectSfr && coreReq.write;

  drax_ram #(.DEPTH(SP_DEPTH)) scratchRam (
    .core_clk(core_clk),
    .rst(rst),
    .we(spWe),
    .addr(coreReq.addr[7:0]),
    .wdata(coreReq.wdata),
    .rdata(spRdata)
  );

  drax_ram #(.DEPTH(AUX_DEPTH)) auxRam (
    .core_clk(core_clk),
    .rst(rst),
    .we(auxHit && coreReq.write),
    .addr(extMoveAddr[9:0]),
    .wdata(coreReq.wdata),
    .rdata(auxRdata)
  );

  // control writes only land while the key sequence has unlocked them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      keyStage_q <= 2'h0;
    end else if (sfrWe && coreReq.addr[7:0] == SFR_UNLOCK_KEY) begin
      if (coreReq.wdata == KEY_FIRST) begin
        keyStage_q <= 2'h1;
      end else if (coreReq.wdata == KEY_SECOND && keyStage_q == 2'h1) begin
        keyStage_q <= 2'h2;
      end else begin
        keyStage_q <= 2'h0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chipCtrl_q <= CHIP_CTRL_RESET;
      xramHigh_q <= XRAM_HIGH_RESET;
    end else if (sfrWe) begin
      if (coreReq.addr[7:0] == SFR_CHIP_CTRL && keyStage_q == 2'h2) begin
        chipCtrl_q <= coreReq.wdata;
      end
      if (coreReq.addr[7:0] == SFR_XRAM_HIGH) begin
        xramHigh_q <= coreReq.wdata;
      end
    end
  end

  // internal answers: one cycle for the RAM read, one to register the result
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      src_q <= SrcNone;
      sfrData_q <= 8'h00;
    end else begin
      pend_q <= accept && !extGo;
      src_q <= spHit ? SrcScratch : (auxHit ? SrcAux : (isDirectSfr ? SrcSfr : SrcNone));
      case (coreReq.addr[7:0])
        SFR_XRAM_HIGH: sfrData_q <= xramHigh_q;
        SFR_CHIP_CTRL: sfrData_q <= chipCtrl_q;
        default: sfrData_q <= 8'h00;
      endcase
    end
  end

  // one-sixth divider; the latch strobe runs free and frames every bus cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 3'h0;
      ale_q <= 1'b1;
    end else begin
      phase_q <= (phase_q == ALE_DIV - 3'h1) ? 3'h0 : phase_q + 3'h1;
      ale_q <= (phase_q == ALE_DIV - 3'h1) || (phase_q + 3'h1 < ALE_HIGH);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      curWrite_q <= 1'b0;
      curFetch_q <= 1'b0;
      curAddr_q <= 16'h0000;
      curData_q <= 8'h00;
    end else if (extGo) begin
      curWrite_q <= coreReq.write && (coreReq.op != OP_FETCH);
      curFetch_q <= coreReq.op == OP_FETCH;
      curAddr_q <= extMoveAddr;
      curData_q <= coreReq.wdata;
    end
  end

  // external cycle: wait for phase 0, address under the strobe, then data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_q <= ExIdle;
      lowOut_q <= 8'hFF;
      lowOe_q <= 1'b0;
      upper_q <= 8'hFF;
      storeStrobeN_q <= 1'b1;
      writeN_q <= 1'b1;
      readN_q <= 1'b1;
    end else begin
      case (ext_q)
        ExIdle: begin
          if (extGo) begin
            ext_q <= ExWait;
          end
        end
        ExWait: begin
          if (phase_q == ALE_DIV - 3'h1) begin
            ext_q <= ExAddr;
            lowOut_q <= curAddr_q[7:0];
            lowOe_q <= 1'b1;
            upper_q <= curAddr_q[15:8];
          end
        end
        ExAddr: begin
          if (phase_q == ALE_HIGH - 3'h1) begin
            ext_q <= ExData;
            lowOut_q <= curData_q;
            lowOe_q <= curWrite_q;
            writeN_q <= !curWrite_q;
            readN_q <= curWrite_q || curFetch_q;
            storeStrobeN_q <= !curFetch_q;
          end
        end
        ExData: begin
          if (phase_q == ALE_DIV - 3'h1) begin
            ext_q <= ExIdle;
            lowOe_q <= 1'b0;
            writeN_q <= 1'b1;
            readN_q <= 1'b1;
            storeStrobeN_q <= 1'b1;
          end
        end
        default: ext_q <= ExIdle;
      endcase
    end
  end

  logic extDone;
  assign extDone = (ext_q == ExData) && (phase_q == ALE_DIV - 3'h1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coreRsp <= '0;
      reqReady <= 1'b0;
      pullupEn_q <= 1'b0;
    end else begin
      pullupEn_q <= pullupRequest;
      coreRsp.valid <= pend_q || extDone;
      coreRsp.external <= extDone;
      if (extDone) begin
        coreRsp.data <= portSync;
      end else if (pend_q) begin
        case (src_q)
          SrcScratch: coreRsp.data <= spRdata;
          SrcAux: coreRsp.data <= auxRdata;
          SrcSfr: coreRsp.data <= sfrData_q;
          default: coreRsp.data <= 8'h00;
        endcase
      end
      reqReady <= accept ? 1'b0 : (reqReady || pend_q || extDone || ext_q == ExIdle && !pend_q);
    end
  end

  sequence s_strobeLow;
    !pins.storeStrobeN [*4];
  endsequence

  a_direct_high_range: assert property (@(posedge core_clk) disable iff (rst)
    spWe && coreReq.op == OP_DIRECT |-> coreReq.addr[7:0] <= DIRECT_LIMIT)
    else $error("direct write reached upper scratchpad");
  a_ale_period: assert property (@(posedge core_clk) disable iff (rst)
    $rose(pins.ale) |-> ##6 $rose(pins.ale))
    else $error("latch strobe period not six cycles");
  a_aux_pins_quiet: assert property (@(posedge core_clk) disable iff (rst)
    auxHit |=> $stable(pins.lowOe) && $stable(pins.upper) && $stable(pins.writeN)
      && $stable(pins.readN))
    else $error("aux access disturbed bus pins");
  a_strobe_fetch_only: assert property (@(posedge core_clk) disable iff (rst)
    $fell(pins.storeStrobeN) |-> curFetch_q ##0 s_strobeLow ##1 pins.storeStrobeN)
    else $error("store strobe outside a four-cycle fetch");
  a_internal_fetch_quiet: assert property (@(posedge core_clk) disable iff (rst)
    accept && coreReq.op == OP_FETCH && extAccSync |=> pins.storeStrobeN [*3])
    else $error("internal fetch drove the bus");
  a_unlock_gate: assert property (@(posedge core_clk) disable iff (rst)
    $changed(chipCtrl_q) |-> $past(keyStage_q) == 2'h2)
    else $error("control changed while locked");
  a_ptr_upper_byte: assert property (@(posedge core_clk) disable iff (rst)
    auxHit && coreReq.op == OP_EXTMOVE_BANKPTR |->
      auxRam.addr == {xramHigh_q[1:0], coreReq.addr[7:0]})
    else $error("pointer aux address lost high byte");
  a_ext_above_limit: assert property (@(posedge core_clk) disable iff (rst)
    accept && isExtMove(coreReq.op) && extMoveAddr > AUX_LIMIT |-> ##[1:7] pins.ale
      && pins.lowOe && pins.lowOut == curAddr_q[7:0] && pins.upper == curAddr_q[15:8])
    else $error("high external move not put on the bus");
  a_internal_answer: assert property (@(posedge core_clk) disable iff (rst)
    spHit |-> ##2 coreRsp.valid && !coreRsp.external)
    else $error("scratchpad answer not two cycles later");
  a_aux_enable: assert property (@(posedge core_clk) disable iff (rst)
    auxHit |-> chipCtrl_q[CHIP_CTRL_AUX_BIT])
    else $error("aux RAM used while disabled");
endmodule // drax_data_access
`default_nettype wire

/* File: verilog/drax_pkg.sv */
// package: constants and types for the data RAM and aux RAM access block
`default_nettype none
package drax_pkg;
  localparam int SP_DEPTH = 256;
  localparam int AUX_DEPTH = 1024;
  localparam logic [7:0] SFR_XRAM_HIGH = 8'hA1;
  localparam logic [7:0] SFR_CHIP_CTRL = 8'hBF;
  localparam logic [7:0] SFR_UNLOCK_KEY = 8'hF6;
  localparam logic [7:0] CHIP_CTRL_RESET = 8'h00;
  localparam logic [7:0] XRAM_HIGH_RESET = 8'h00;
  localparam int CHIP_CTRL_AUX_BIT = 4;
  localparam logic [7:0] KEY_FIRST = 8'h87;
  localparam logic [7:0] KEY_SECOND = 8'h59;
  localparam logic [7:0] KEY_LOCK = 8'h00;
  localparam logic [15:0] AUX_LIMIT = 16'h03FF;
  localparam logic [7:0] DIRECT_LIMIT = 8'h7F;
  localparam logic [2:0] ALE_DIV = 3'h6;
  localparam logic [2:0] ALE_HIGH = 3'h2;

  typedef enum logic [2:0] {
    OP_DIRECT,
    OP_INDIRECT,
    OP_EXTMOVE_BANKPTR,
    OP_EXTMOVE_DATAPTR,
    OP_FETCH
  } drax_op_t;

  typedef struct packed {
    logic valid;
    drax_op_t op;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } drax_req_t;

  typedef struct packed {
    logic valid;
    logic external;
    logic [7:0] data;
  } drax_rsp_t;

  typedef struct packed {
    logic [7:0] lowOut;
    logic lowOe;
    logic [7:0] upper;
    logic ale;
    logic storeStrobeN;
    logic writeN;
    logic readN;
    logic pullupEn;
  } drax_pins_t;
endpackage
`default_nettype wire

/* File: verilog/drax_ram.sv */
// single-port synchronous RAM used for scratchpad and aux RAM
`timescale 1ns/1ps
`default_nettype none
module drax_ram #(
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule // drax_ram
`default_nettype wire

/* File: sim/drax_ext_mem.sv */
// external memory model on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module drax_ext_mem (
  input wire logic core_clk,
  input wire drax_pkg::drax_pins_t pins,
  output logic [7:0] lowPortIn,
  output logic [15:0] lastAddr
);
  import drax_pkg::*;
  logic [7:0] mem [int];
  initial lowPortIn = 8'hFF;
  initial lastAddr = 16'h0000;
  // unwritten places answer with a pattern built from their address
  always @(posedge core_clk) begin
    if (pins.ale && pins.lowOe && pins.writeN) lastAddr <= {pins.upper, pins.lowOut};
    if (!pins.writeN) mem[lastAddr] = pins.lowOut;
    if (!pins.readN || !pins.storeStrobeN) begin
      lowPortIn <= mem.exists(lastAddr) ? mem[lastAddr] : lastAddr[15:8] ^ lastAddr[7:0];
    end else begin
      // released port: pull-ups if on, else a value that keeps changing
      lowPortIn <= pins.pullupEn ? 8'hFF : ~lowPortIn;
    end
  end
endmodule // drax_ext_mem
`default_nettype wire

/* File: sim/data_ram_and_aux_ram_access_tb_top.sv */
// self-checking testbench for the data RAM and aux RAM access block
`timescale 1ns/1ps
`default_nettype none
module data_ram_and_aux_ram_access_tb_top;
  import drax_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  drax_req_t coreReq = '0;
  logic pullupRequest = 1'b0;
  logic external_access_n = 1'b1;
  logic reqReady;
  drax_rsp_t coreRsp;
  drax_pins_t pins;
  logic [7:0] lowPortIn;
  logic [15:0] lastAddr;
  logic [7:0] rd;
  logic ex;
  int lat;
  int errors = 0;
  int n_checks = 0;
  int strobes = 0;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (pins.storeStrobeN === 1'b0) strobes++;
  drax_data_access dut (.core_clk(core_clk), .rst(rst), .coreReq(coreReq),
    .reqReady(reqReady), .coreRsp(coreRsp), .pullupRequest(pullupRequest),
    .external_access_n(external_access_n), .lowPortIn(lowPortIn), .pins(pins));
  drax_ext_mem mem (.core_clk(core_clk), .pins(pins), .lowPortIn(lowPortIn),
    .lastAddr(lastAddr));

  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [19:0] busPins(input drax_pins_t p);
    return {p.lowOut, p.lowOe, p.upper, p.writeN, p.readN, p.storeStrobeN};
  endfunction

  // one request, held until taken; answer sampled at the falling edge
  task automatic xfer(input drax_op_t op, input logic w, input logic [15:0] a,
      input logic [7:0] d);
    drax_pins_t pinsBefore;
    int n;
    n = 0;
    @(posedge core_clk);
    coreReq <= '{1'b1, op, w, a, d};
    do begin @(negedge core_clk); n++; end while (reqReady !== 1'b1 && n < 40);
    @(posedge core_clk);
    coreReq.valid <= 1'b0;
    pinsBefore = pins;
    lat = 0;
    do begin @(negedge core_clk); lat++; end while (coreRsp.valid !== 1'b1 && lat < 40);
    if (n >= 40 || lat >= 40) begin
      errors++;
      end_sim();
    end
    rd = coreRsp.data;
    ex = coreRsp.external;
    if (ex === 1'b0) begin
      chk("internal latency", 20'(lat), 20'd2);
      chk("quiet bus", busPins(pins), busPins(pinsBefore));
    end else begin
      chk("external latency", 20'(lat >= 8 && lat <= 13), 20'd1);
    end
  endtask

  task automatic t_regs;
    xfer(OP_DIRECT, 1'b0, 16'h00A1, 8'h00);
    chk("aux high reset", rd, XRAM_HIGH_RESET);
    xfer(OP_DIRECT, 1'b0, 16'h00BF, 8'h00);
    chk("control reset", rd, CHIP_CTRL_RESET);
    xfer(OP_DIRECT, 1'b1, 16'h00BF, 8'h10);
    xfer(OP_DIRECT, 1'b0, 16'h00BF, 8'h00);
    chk("locked control", rd, 8'h00);
    xfer(OP_EXTMOVE_DATAPTR, 1'b1, 16'h0134, 8'h78);
    chk("aux off goes out", ex, 1'b1);
    xfer(OP_DIRECT, 1'b1, 16'h00F6, KEY_FIRST);
    xfer(OP_DIRECT, 1'b1, 16'h00F6, KEY_SECOND);
    xfer(OP_DIRECT, 1'b1, 16'h00BF, 8'h10);
    xfer(OP_DIRECT, 1'b1, 16'h00F6, KEY_LOCK);
    xfer(OP_DIRECT, 1'b0, 16'h00BF, 8'h00);
    chk("control set", rd, 8'h10);
    xfer(OP_DIRECT, 1'b0, 16'h00F6, 8'h00);
    chk("key reads zero", rd, 8'h00);
    $display("registers done");
  endtask

  task automatic t_scratch;
    xfer(OP_DIRECT, 1'b1, 16'h007F, 8'h3C);
    xfer(OP_INDIRECT, 1'b0, 16'h007F, 8'h00);
    chk("direct to pointer", rd, 8'h3C);
    xfer(OP_INDIRECT, 1'b1, 16'h0000, 8'hE1);
    xfer(OP_DIRECT, 1'b0, 16'h0000, 8'h00);
    chk("pointer to direct", rd, 8'hE1);
    xfer(OP_INDIRECT, 1'b1, 16'h0080, 8'hC3);
    xfer(OP_INDIRECT, 1'b1, 16'h00FF, 8'h5A);
    xfer(OP_DIRECT, 1'b0, 16'h0080, 8'h00);
    chk("direct upper half", rd, 8'h00);
    xfer(OP_INDIRECT, 1'b0, 16'h0080, 8'h00);
    chk("pointer 80", rd, 8'hC3);
    xfer(OP_INDIRECT, 1'b0, 16'h00FF, 8'h00);
    chk("pointer FF", rd, 8'h5A);
    $display("scratchpad done");
  endtask

  task automatic t_aux;
    xfer(OP_DIRECT, 1'b1, 16'h00A1, 8'h01);
    xfer(OP_EXTMOVE_BANKPTR, 1'b1, 16'h0023, 8'h55);
    chk("aux write inside", ex, 1'b0);
    xfer(OP_EXTMOVE_DATAPTR, 1'b0, 16'h0123, 8'h00);
    chk("pointer high byte", rd, 8'h55);
    xfer(OP_EXTMOVE_DATAPTR, 1'b1, 16'h03FF, 8'hAA);
    xfer(OP_DIRECT, 1'b1, 16'h00A1, 8'h03);
    xfer(OP_EXTMOVE_BANKPTR, 1'b0, 16'h00FF, 8'h00);
    chk("aux top", {ex, rd}, 9'h0AA);
    xfer(OP_EXTMOVE_DATAPTR, 1'b1, 16'h0000, 8'h11);
    xfer(OP_DIRECT, 1'b0, 16'h0000, 8'h00);
    chk("banks apart", rd, 8'hE1);
    xfer(OP_EXTMOVE_DATAPTR, 1'b1, 16'h0400, 8'h66);
    chk("above limit out", ex, 1'b1);
    xfer(OP_EXTMOVE_DATAPTR, 1'b0, 16'h0400, 8'h00);
    chk("bus read", {ex, rd}, 9'h166);
    chk("bus address", lastAddr, 16'h0400);
    $display("aux done");
  endtask

  task automatic t_fetch;
    int s;
    s = strobes;
    xfer(OP_FETCH, 1'b0, 16'h1234, 8'h00);
    chk("internal fetch", {ex, rd}, 9'h000);
    chk("no store strobe", 20'(strobes - s), 20'd0);
    @(posedge core_clk);
    external_access_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    xfer(OP_FETCH, 1'b0, 16'h1234, 8'h00);
    chk("external fetch", {ex, rd}, 9'h126);
    chk("store strobe cycles", 20'(strobes - s), 20'd4);
    @(posedge core_clk);
    external_access_n <= 1'b1;
    $display("fetch done");
  endtask

  task automatic t_pins;
    int rises;
    int highs;
    logic prev;
    rises = 0;
    highs = 0;
    @(negedge core_clk);
    prev = pins.ale;
    chk("pull-up off", pins.pullupEn, 1'b0);
    repeat (60) begin
      @(negedge core_clk);
      if (pins.ale === 1'b1 && prev === 1'b0) rises++;
      if (pins.ale === 1'b1) highs++;
      prev = pins.ale;
    end
    chk("latch strobe rate", 20'(rises), 20'd10);
    chk("latch strobe high", 20'(highs), 20'd20);
    @(posedge core_clk);
    pullupRequest <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("pull-up on", pins.pullupEn, 1'b1);
    $display("pins done");
  endtask

  initial begin
    // reset held well past two machine cycles
    repeat (16) @(posedge core_clk);
    chk("reset pins", {pins.ale, pins.lowOe, pins.upper, pins.storeStrobeN}, 11'h5FF);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_scratch();
    t_aux();
    t_fetch();
    t_pins();
    end_sim();
  end
endmodule // data_ram_and_aux_ram_access_tb_top
`default_nettype wire
